// file: design/sclk_map.vh
// constants for the system clock select and prescale block
// assumes an 8-bit register port with byte addresses
`ifndef SCLK_MAP_VH
`define SCLK_MAP_VH

// register address of clock_control
`define SCLK_ADDR_CLOCK_CONTROL 8'hD8

// field positions inside clock_control
`define SCLK_BIT_SLOW_TYPE 7
`define SCLK_BIT_FAST_TYPE 6
`define SCLK_BIT_SLOW_RC_HALT 5
`define SCLK_BIT_PERIPH_HALT 4
`define SCLK_BIT_FAST_HALT 3
`define SCLK_BIT_SRC_FAST 2
`define SCLK_DIV_MSB 1
`define SCLK_DIV_LSB 0

// reset values
`define SCLK_RST_CLOCK_CONTROL 8'h23
`define SCLK_RST_DIV 2'h3

// divider codes
`define SCLK_DIV_BY16 2'h0
`define SCLK_DIV_BY4 2'h1
`define SCLK_DIV_BY2 2'h2
`define SCLK_DIV_BY1 2'h3

// source half-period events per output half-period, minus one
`define SCLK_HALF_BY16 4'hF
`define SCLK_HALF_BY4 4'h3
`define SCLK_HALF_BY2 4'h1
`define SCLK_HALF_BY1 4'h0

`endif

// file: design/sclk_clkgen.v
// glitch-free source switch and prescaler for the system clock
// assumes one-cycle edge events from both oscillators, already synchronised
`timescale 1ns/1ps
`include "sclk_map.vh"

module sclk_clkgen (
    // clock, reset, enable
    input wire i_clk,
    input wire i_rst_b,
    input wire i_ce,
    // source edge events (either edge of the oscillator)
    input wire i_slow_evt,
    input wire i_fast_evt,
    // requested settings from the register
    input wire i_sel_fast,
    input wire [1:0] i_div,
    // generated clock and the settings now in force
    output reg o_sys_clk,
    output reg o_cur_fast,
    output reg [1:0] o_cur_div
);

    reg [3:0] cnt; // source half-period events seen in this output phase
    reg skip; // first edge of a newly chosen source is not counted
    wire evt; // edge of the source now in force
    wire [3:0] limit; // terminal count for the divide now in force

    // half-period length per divide code
    function [3:0] sclk_half_limit;
        input [1:0] code;
        begin
            case (code)
                `SCLK_DIV_BY16: sclk_half_limit = `SCLK_HALF_BY16;
                `SCLK_DIV_BY4: sclk_half_limit = `SCLK_HALF_BY4;
                `SCLK_DIV_BY2: sclk_half_limit = `SCLK_HALF_BY2;
                default: sclk_half_limit = `SCLK_HALF_BY1;
            endcase
        end
    endfunction

    assign evt = o_cur_fast ? i_fast_evt : i_slow_evt;
    assign limit = sclk_half_limit(o_cur_div);

    // each phase lasts limit+1 source half periods; new settings are only taken
    // as the output falls, so the low phase that follows is a full one of the
    // new setting and no high or low pulse is ever cut short
    // the worst wait is one div-16 period, i.e. 16 source cycles
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 4'h0;
            skip <= 1'b0;
            o_sys_clk <= 1'b0;
            o_cur_fast <= 1'b0;
            o_cur_div <= `SCLK_RST_DIV;
        end else if (i_ce && evt) begin
            if (skip) begin
                // a new source's phase is unrelated to the switch point, so its first
                // edge may come at once; dropping it keeps the low phase whole
                skip <= 1'b0;
            end else if (cnt == limit) begin
                cnt <= 4'h0;
                o_sys_clk <= ~o_sys_clk;
                if (o_sys_clk) begin
                    // falling edge: safe point to change source and ratio
                    o_cur_fast <= i_sel_fast;
                    o_cur_div <= i_div;
                    skip <= (i_sel_fast != o_cur_fast);
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end

endmodule

// file: design/sclk_ctrl.v
// system clock control: clock_control register, oscillator gating and
// the generated system clock
// assumes oscillator outputs arrive asynchronously on pins and are sampled at
// 40 MHz, and that the core reports idle and power-down as same-clock levels
`timescale 1ns/1ps
`include "sclk_map.vh"

// Notes on behaviour
// - slow type: rc or crystal, fast mode only
// - fast type: rc or crystal, slow mode only
// - slow rc halts in power-down; resets high
// - peripheral clock gated off during idle
// - fast halt in slow mode (idle has no effect); slow mode only
// - source select, reset slow; needs fast running
// - divider 16/4/2/1, reset undivided
// - new divider active within 16 source cycles
module sclk_ctrl (
    // clock, reset, enable
    input wire i_clk,
    input wire i_rst_b,
    input wire i_ce,
    // register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // core power state
    input wire i_idle,
    input wire i_power_down_state,
    // oscillator outputs (asynchronous)
    input wire i_internal_slow_rc,
    input wire i_external_slow_crystal,
    input wire i_internal_fast_rc,
    input wire i_external_fast_crystal,
    // oscillator enables
    output reg o_internal_slow_rc_en,
    output reg o_external_slow_crystal_en,
    output reg o_internal_fast_rc_en,
    output reg o_external_fast_crystal_en,
    output reg o_fast_gain_high,
    // crystal_pin_a and crystal_pin_b given over to a crystal
    output reg o_crystal_pins_en,
    // clocks out
    output wire o_sys_clk,
    output reg o_periph_clk_en,
    output reg o_sys_is_fast
);

    // clock_control fields
    reg slow_source_type; // 0 internal rc, 1 crystal
    reg fast_source_type; // 0 internal rc, 1 crystal
    reg slow_rc_halt_in_powerdown;
    reg peripheral_clock_halt_idle;
    reg fast_oscillator_halt;
    reg system_source_is_fast;
    reg [1:0] system_clock_divider;

    // next values of the guarded bits
    reg next_slow_type;
    reg next_fast_type;
    reg next_fast_halt;
    reg next_src_fast;

    // synchronisers: three stages per oscillator
    reg [2:0] sync_srt; // slow rc
    reg [2:0] sync_sxt; // slow crystal
    reg [2:0] sync_frt; // fast rc
    reg [2:0] sync_fxt; // fast crystal
    reg slow_lvl; // agreed level of the chosen slow source
    reg fast_lvl; // agreed level of the chosen fast source

    wire wr_hit; // write to clock_control
    wire rd_hit; // read of clock_control
    wire [7:0] reg_value; // assembled register image
    wire slow_s2; // stage two of the chosen slow source
    wire slow_s3; // stage three of the chosen slow source
    wire fast_s2;
    wire fast_s3;
    wire slow_evt; // agreed change of the slow source
    wire fast_evt; // agreed change of the fast source
    wire cur_fast; // source actually driving the system clock
    localparam [7:0] RST_IMAGE = `SCLK_RST_CLOCK_CONTROL; // clock_control after reset

    assign wr_hit = i_wr && (i_addr == `SCLK_ADDR_CLOCK_CONTROL);
    assign rd_hit = i_rd && (i_addr == `SCLK_ADDR_CLOCK_CONTROL);

    assign reg_value = {slow_source_type, fast_source_type, slow_rc_halt_in_powerdown,
                        peripheral_clock_halt_idle, fast_oscillator_halt,
                        system_source_is_fast, system_clock_divider};

    // guarded bits: a write outside the allowed mode is dropped silently
    always @* begin
        next_slow_type = slow_source_type;
        next_fast_type = fast_source_type;
        next_fast_halt = fast_oscillator_halt;
        next_src_fast = system_source_is_fast;
        if (wr_hit) begin
            // slow type only while the fast clock is selected and in force
            if (system_source_is_fast && cur_fast) begin
                next_slow_type = i_wdata[`SCLK_BIT_SLOW_TYPE];
            end
            // fast type and fast halt only in slow mode, selected and in force;
            // a type change under a pending switch could cut a pulse
            if (!system_source_is_fast && !cur_fast) begin
                next_fast_type = i_wdata[`SCLK_BIT_FAST_TYPE];
                next_fast_halt = i_wdata[`SCLK_BIT_FAST_HALT];
            end
            // source select only while the fast oscillator may run
            if (!fast_oscillator_halt) begin
                next_src_fast = i_wdata[`SCLK_BIT_SRC_FAST];
            end
        end
    end

    // register file; the guards look at the old value, so one write cannot
    // both unlock and change a bit
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slow_source_type <= RST_IMAGE[`SCLK_BIT_SLOW_TYPE];
            fast_source_type <= RST_IMAGE[`SCLK_BIT_FAST_TYPE];
            slow_rc_halt_in_powerdown <= RST_IMAGE[`SCLK_BIT_SLOW_RC_HALT];
            peripheral_clock_halt_idle <= RST_IMAGE[`SCLK_BIT_PERIPH_HALT];
            fast_oscillator_halt <= RST_IMAGE[`SCLK_BIT_FAST_HALT];
            system_source_is_fast <= RST_IMAGE[`SCLK_BIT_SRC_FAST];
            system_clock_divider <= RST_IMAGE[`SCLK_DIV_MSB:`SCLK_DIV_LSB];
        end else if (i_ce) begin
            slow_source_type <= next_slow_type;
            fast_source_type <= next_fast_type;
            fast_oscillator_halt <= next_fast_halt;
            system_source_is_fast <= next_src_fast;
            if (wr_hit) begin
                // unguarded fields
                slow_rc_halt_in_powerdown <= i_wdata[`SCLK_BIT_SLOW_RC_HALT];
                peripheral_clock_halt_idle <= i_wdata[`SCLK_BIT_PERIPH_HALT];
                system_clock_divider <= i_wdata[`SCLK_DIV_MSB:`SCLK_DIV_LSB];
            end
        end
    end

    // read data stand only in the cycle after the strobe; unmapped reads zero
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= rd_hit ? reg_value : 8'h00;
        end
    end

    // oscillator samplers; stage one feeds stage two only
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_srt <= 3'h0;
            sync_sxt <= 3'h0;
            sync_frt <= 3'h0;
            sync_fxt <= 3'h0;
        end else if (i_ce) begin
            sync_srt <= {sync_srt[1:0], i_internal_slow_rc};
            sync_sxt <= {sync_sxt[1:0], i_external_slow_crystal};
            sync_frt <= {sync_frt[1:0], i_internal_fast_rc};
            sync_fxt <= {sync_fxt[1:0], i_external_fast_crystal};
        end
    end

    // pick the oscillator by its type bit
    assign slow_s2 = slow_source_type ? sync_sxt[1] : sync_srt[1];
    assign slow_s3 = slow_source_type ? sync_sxt[2] : sync_srt[2];
    assign fast_s2 = fast_source_type ? sync_fxt[1] : sync_frt[1];
    assign fast_s3 = fast_source_type ? sync_fxt[2] : sync_frt[2];

    // a change counts once stages two and three agree on a new level
    assign slow_evt = (slow_s2 == slow_s3) && (slow_s3 != slow_lvl);
    assign fast_evt = (fast_s2 == fast_s3) && (fast_s3 != fast_lvl);

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slow_lvl <= 1'b0;
            fast_lvl <= 1'b0;
        end else if (i_ce) begin
            if (slow_evt) begin
                slow_lvl <= slow_s3;
            end
            if (fast_evt) begin
                fast_lvl <= fast_s3;
            end
        end
    end

    // prescaler and glitch-free switch
    sclk_clkgen u_clkgen (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_slow_evt(slow_evt),
        .i_fast_evt(fast_evt),
        .i_sel_fast(system_source_is_fast),
        .i_div(system_clock_divider),
        .o_sys_clk(o_sys_clk),
        .o_cur_fast(cur_fast),
        .o_cur_div()
    );

    // oscillator gating; the fast oscillator is kept running until the switch
    // has really left it, otherwise the switch would wait for an edge forever
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_internal_slow_rc_en <= 1'b1;
            o_external_slow_crystal_en <= 1'b0;
            o_internal_fast_rc_en <= 1'b1;
            o_external_fast_crystal_en <= 1'b0;
            o_fast_gain_high <= 1'b0;
            o_crystal_pins_en <= 1'b0;
            o_periph_clk_en <= 1'b1;
            o_sys_is_fast <= 1'b0;
        end else if (i_ce) begin
            // slow rc stops in power-down when asked
            o_internal_slow_rc_en <= !slow_source_type &&
                                     !(slow_rc_halt_in_powerdown && i_power_down_state);
            o_external_slow_crystal_en <= slow_source_type;
            // fast source stops in slow operation when asked; idle does not stop it
            o_internal_fast_rc_en <= !fast_source_type && !(fast_oscillator_halt && !cur_fast);
            o_external_fast_crystal_en <= fast_source_type && !(fast_oscillator_halt && !cur_fast);
            o_fast_gain_high <= fast_source_type;
            o_crystal_pins_en <= slow_source_type || fast_source_type;
            // peripheral clock off in idle when asked
            o_periph_clk_en <= !(peripheral_clock_halt_idle && i_idle);
            o_sys_is_fast <= cur_fast;
        end
    end

endmodule

// file: verification/sclk_osc_model.sv
// oscillator model for the clock control block: four sources
// assumes the enables come straight from sclk_ctrl
`timescale 1ns/1ps
module sclk_osc_model (
    // enables: slow rc, slow crystal, fast rc, fast crystal
    input wire [3:0] i_en,
    // waveforms; a stopped oscillator rests low
    output reg [3:0] o_osc = 4'h0
);
    // distinct periods (500/600/200/250 ns) let the bench tell sources apart
    always #250 o_osc[3] = i_en[3] ? ~o_osc[3] : 1'b0;
    always #300 o_osc[2] = i_en[2] ? ~o_osc[2] : 1'b0;
    always #100 o_osc[1] = i_en[1] ? ~o_osc[1] : 1'b0;
    always #125 o_osc[0] = i_en[0] ? ~o_osc[0] : 1'b0;
endmodule

// file: verification/sclk_ctrl_properties.sv
// checker for the clock control block: gating, enables, pulse shape
// assumes binding to sclk_ctrl, one clock, async active-low reset
`timescale 1ns/1ps
module sclk_ctrl_properties (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // register writes and power state
    input wire i_ce,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_idle,
    input wire i_power_down_state,
    // enables and clocks
    input wire o_internal_slow_rc_en,
    input wire o_external_slow_crystal_en,
    input wire o_internal_fast_rc_en,
    input wire o_external_fast_crystal_en,
    input wire o_fast_gain_high,
    input wire o_crystal_pins_en,
    input wire o_sys_clk,
    input wire o_periph_clk_en,
    input wire o_sys_is_fast
);
    reg [1:0] halt; // shadow of halt bits 5:4, which have no guard
    reg prev; // system clock one cycle back
    reg [15:0] run; // cycles since last clock edge; saturates so reset never fakes a short pulse
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // shadow the halt bits and time each system clock level
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            halt <= 2'h2;
            prev <= 1'b0;
            run <= 16'hFFFF;
        end else begin
            if (i_ce && i_wr && i_addr == 8'hD8) halt <= i_wdata[5:4];
            prev <= o_sys_clk;
            run <= (o_sys_clk != prev) ? 16'h0001 : run + {15'h0000, run != 16'hFFFF};
        end
    end
    a_periph_gate: assert property ($past(i_ce) |-> o_periph_clk_en == !$past(i_idle && halt[0]))
        else $error("peripheral clock gate wrong");
    a_slow_rc_halt: assert property ($past(i_ce && i_power_down_state && halt[1]) |-> !o_internal_slow_rc_en)
        else $error("slow rc still runs in power-down");
    a_slow_one_type: assert property ($past(i_ce && !i_power_down_state) |->
        o_internal_slow_rc_en != o_external_slow_crystal_en) else $error("slow source enables wrong");
    a_fast_kept: assert property (o_sys_is_fast |-> o_internal_fast_rc_en || o_external_fast_crystal_en)
        else $error("fast oscillator stopped while in use");
    a_fast_one_type: assert property (!(o_internal_fast_rc_en && o_external_fast_crystal_en))
        else $error("both fast sources enabled");
    a_gain_pins: assert property (o_fast_gain_high |-> o_crystal_pins_en)
        else $error("high gain without crystal pins");
    a_pulse_whole: assert property (o_sys_clk != prev |-> run >= 16'd3)
        else $error("shortened system clock pulse");
    a_switch_low: assert property ($changed(o_sys_is_fast) |-> !o_sys_clk)
        else $error("source switched while clock high");
endmodule
bind sclk_ctrl sclk_ctrl_properties u_props (.i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_idle,
    .i_power_down_state, .o_internal_slow_rc_en, .o_external_slow_crystal_en, .o_internal_fast_rc_en,
    .o_external_fast_crystal_en, .o_fast_gain_high, .o_crystal_pins_en, .o_sys_clk,
    .o_periph_clk_en, .o_sys_is_fast);

// file: verification/tb_top.sv
// self-checking bench for sclk_ctrl: register port, guards, gating, divider
// assumes the design, the oscillator model and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
    reg i_clk = 1'b0; // 40 MHz
    reg i_rst_b = 1'b0; // active-low reset
    reg [7:0] i_addr = 8'h00; // register port
    reg [7:0] i_wdata = 8'h00;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg i_idle = 1'b0; // core power state
    reg i_power_down_state = 1'b0;
    reg i_ce = 1'b1; // clock enable
    wire o_fast_gain_high, o_crystal_pins_en;
    wire [7:0] o_rdata;
    wire [3:0] en; // slow rc, slow xtal, fast rc, fast xtal
    wire [3:0] osc;
    wire o_sys_clk, o_periph_clk_en, o_sys_is_fast;
    integer fail_count = 0, samples_checked = 0, i, k, got;
    reg [7:0] exp_reg, w; // register model and write data
    reg pc; // system clock at the previous sample
    sclk_ctrl uut (.i_clk, .i_rst_b, .i_ce(i_ce), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_idle,
        .i_power_down_state, .i_internal_slow_rc(osc[3]), .i_external_slow_crystal(osc[2]),
        .i_internal_fast_rc(osc[1]), .i_external_fast_crystal(osc[0]), .o_internal_slow_rc_en(en[3]),
        .o_external_slow_crystal_en(en[2]), .o_internal_fast_rc_en(en[1]), .o_external_fast_crystal_en(en[0]),
        .o_fast_gain_high, .o_crystal_pins_en, .o_sys_clk, .o_periph_clk_en, .o_sys_is_fast);
    sclk_osc_model osc_m (.i_en(en), .o_osc(osc));
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    // register after a write; guards look at the old value
    function [7:0] nxt(input [7:0] o, input [7:0] d);
        begin
            nxt = {o[7:6], d[5:4], o[3:2], d[1:0]};
            if (o[2]) nxt[7] = d[7];
            else begin
                nxt[6] = d[6];
                nxt[3] = d[3];
            end
            if (!o[3]) nxt[2] = d[2];
        end
    endfunction
    // system clock period in bench clocks
    function integer per(input [7:0] r);
        begin
            per = r[2] ? (r[6] ? 10 : 8) : (r[7] ? 24 : 20);
            per = per << (r[1:0] == 2'h0 ? 4 : 3 - r[1:0]);
        end
    endfunction
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        begin
            samples_checked++;
            if (s !== e) begin
                fail_count++;
                $display("unexpected %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask
    // one write to clock_control; first waits, with power-down low, until the source
    // in force matches the select bit, so the guards read as the model assumes
    task put(input [7:0] d, input idl, input pdn);
        integer n;
        begin
            @(posedge i_clk);
            i_power_down_state <= 1'b0;
            #1;
            for (n = 0; n < 1000 && o_sys_is_fast !== exp_reg[2]; n++) begin
                @(posedge i_clk);
                #1;
            end
            @(posedge i_clk);
            i_idle <= idl;
            i_power_down_state <= pdn;
            wr(8'hD8, d);
            exp_reg = nxt(exp_reg, d);
        end
    endtask
    // data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1 chk("rdata", e, o_rdata);
        end
    endtask
    // clocks between the second and third rising edge
    task meas(output integer n);
        integer j, e, t0;
        begin
            e = 0;
            t0 = 0;
            n = 0;
            pc = o_sys_clk;
            for (j = 0; j < 3000 && e < 3; j++) begin
                @(posedge i_clk);
                #1;
                if (o_sys_clk && !pc) begin
                    e++;
                    if (e == 2) t0 = j;
                    if (e == 3) n = j - t0;
                end
                pc = o_sys_clk;
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // watchdog: the tests need about 45000 clocks at worst
    initial begin
        repeat (90000) @(posedge i_clk);
        fail_count++;
        finish_test;
    end
    initial begin
        void'($urandom(84));
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        exp_reg = 8'h23;
        rd(8'hD8, 8'h23);
        wr(8'hD9, 8'hFF);
        rd(8'hD9, 8'h00);
        rd(8'hD8, exp_reg);
        // with the clock enable low a write must not land; done on the slow rc,
        // whose long half period outlasts the short freeze
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(8'hD8, exp_reg ^ 8'h33);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rd(8'hD8, exp_reg);
        // random writes under random idle and power-down
        for (i = 0; i < 60; i++) begin
            w = 8'($urandom);
            put(w, 1'($urandom), 1'($urandom));
            rd(8'hD8, exp_reg);
            chk("periph_en", !(i_idle && exp_reg[4]), o_periph_clk_en);
            chk("slow_rc_en", !exp_reg[7] && !(i_power_down_state && exp_reg[5]), en[3]);
            chk("slow_xtal_en", exp_reg[7], en[2]);
            chk("gain_high", exp_reg[6], o_fast_gain_high);
            chk("crystal_pins", exp_reg[7] | exp_reg[6], o_crystal_pins_en);
        end
        // both source selects and every divide code, oscillator types random; written twice since a cleared halt frees the select
        for (i = 0; i < 8; i++) begin
            w = (8'($urandom) & 8'hC0) | 8'h20 | {5'h00, i[2:0]};
            repeat (2) put(w, 1'b0, 1'b0);
            #1;
            for (k = 0; k < 1000 && o_sys_is_fast !== exp_reg[2]; k++) begin
                @(posedge i_clk);
                #1;
            end
            chk("src_in_force", exp_reg[2], o_sys_is_fast);
            meas(got);
            chk("sys_period", 1, got >= per(exp_reg) - 2 && got <= per(exp_reg) + 2);
        end
        // reset again in mid-run
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(8'hD8, 8'h23);
        finish_test;
    end
endmodule
